/* File: hw/fhb_bridge.sv */
// Fieldbus to HART frame bridge: pass-through, universal frames, triggers, buffer map
`timescale 1ns/1ps
`default_nettype none
`include "fhb_defs.svh"
module fhb_bridge #(
   parameter logic [31:0] RESP_WAIT_CYC = `FHB_RESP_WAIT_MS * (`FHB_CLK_HZ / 1000)
) (
   input  wire logic                   ref_clk,
   input  wire logic                   resetn,
   input  wire logic                   mode_common,
   input  wire logic                   mode_profibus,
   input  wire logic [15:0]            bit_cycles,
   input  wire logic [7:0]             ser_rx_data,
   input  wire logic                   ser_rx_valid,
   output logic      [7:0]             ser_tx_data,
   output logic                        ser_tx_valid,
   input  wire logic                   ser_tx_ready,
   output logic      [7:0]             hart_tx_data,
   output logic                        hart_tx_valid,
   input  wire logic                   hart_tx_ready,
   output logic                        hart_tx_end,
   input  wire logic [7:0]             hart_rx_data,
   input  wire logic                   hart_rx_valid,
   input  wire logic                   hart_rx_end,
   output logic                        trig_req,
   output logic      [7:0]             trig_num,
   input  wire logic                   host_req,
   input  wire logic                   host_we,
   input  wire logic [`FHB_MEM_AW-1:0] host_addr,
   input  wire logic [7:0]             host_wdata,
   output logic      [7:0]             host_rdata,
   output logic                        host_rvalid,
   input  wire logic                   pb_req,
   input  wire logic                   pb_we,
   input  wire logic [7:0]             pb_idx,
   input  wire logic [7:0]             pb_wdata,
   input  wire logic                   pb_lock,
   output logic                        pb_refused,
   input  wire logic                   mod_valid,
   input  wire logic [1:0]             mod_kind,
   input  wire logic [6:0]             mod_words,
   input  wire logic [8:0]             cfg_in_bytes,
   input  wire logic [8:0]             cfg_out_bytes,
   input  wire logic [6:0]             cfg_mods,
   output logic                        cfg_err,
   output logic      [1:0]             gw_status
);
   function automatic logic [`FHB_MEM_AW-1:0] fhb_off(input logic [`FHB_MEM_AW-1:0] base,
                                                      input logic [8:0] n);
      fhb_off = `FHB_MEM_AW'(base + {4'h0, n});
   endfunction

   function automatic logic fhb_mod_ok(input logic [1:0] kind, input logic [6:0] words);
      unique case (kind)
         `FHB_MOD_COMBO: fhb_mod_ok = (words == 7'h04) || (words == 7'h08) ||
                                      (words == 7'h18) || (words == 7'h38);
         `FHB_MOD_IN,
         `FHB_MOD_OUT:   fhb_mod_ok = (words <= 7'h40);
         `FHB_MOD_CONS:  fhb_mod_ok = (words >= 7'h02) && (words <= 7'h10);
      endcase
   endfunction

   fhb_pkg::fhb_state_t state, next_state;
   logic [8:0]  idx, next_idx, len, next_len, rx_cnt, next_rx_cnt;
   logic        is_trig, next_is_trig;
   logic [31:0] tmr, next_tmr, idle_cnt, next_idle_cnt, idle_lim;
   logic        frame_open, next_frame_open;
   logic [7:0]  uni_rx_label, next_uni_rx_label, uni_err, next_uni_err;
   logic [7:0]  trig_label, next_trig_label, trig_num_s, next_trig_num_s;
   logic [7:0]  uni_tx_label, next_uni_tx_label, uni_en, next_uni_en;
   logic        trig_pend, next_trig_pend, uni_pend, next_uni_pend;
   logic [7:0]  next_hart_tx_data, next_ser_tx_data, next_trig_num;
   logic        next_hart_tx_valid, next_hart_tx_end, next_ser_tx_valid, next_trig_req;
   logic        next_host_rvalid, next_pb_refused, next_cfg_err;
   logic        mod_bad, next_mod_bad;
   logic [1:0]  next_gw_status;
   logic        b_we, next_b_we, b_blocked, b_free;
   logic [`FHB_MEM_AW-1:0] b_waddr, next_b_waddr, b_raddr, a_addr;
   logic [7:0]  b_wdata, next_b_wdata, b_rdata;
   logic        a_en, a_we, pb_in_range;
   logic [7:0]  a_wdata;
   logic        wr_ok;
   logic [`FHB_MEM_AW-1:0] rx_base;

   // bit period x 10 x 3.5, as x7/2
   assign idle_lim = 32'(({16'h0000, bit_cycles} * `FHB_BITS_PER_CHAR * `FHB_IDLE_NUM)
                         / `FHB_IDLE_DEN);

   assign pb_in_range = ({1'b0, pb_idx} < `FHB_PB_MAX_BYTES);

   always_comb begin
      if (mode_profibus) begin
         a_en    = pb_req && pb_in_range;
         a_we    = pb_we;
         a_wdata = pb_wdata;
         // input reads from 0, output writes to 3000
         a_addr  = pb_we ? fhb_off(`FHB_PB_OUT_BASE, {1'b0, pb_idx})
                         : fhb_off(`FHB_PB_IN_BASE, {1'b0, pb_idx});
      end else begin
         a_en    = host_req;
         a_we    = host_we;
         a_wdata = host_wdata;
         a_addr  = host_addr;
      end
   end

   // hold engine writes to the input area while a consistent read runs
   assign b_blocked = mode_profibus && pb_lock && (b_waddr < fhb_off(`FHB_PB_IN_BASE,
                                                                     `FHB_PB_MAX_BYTES));
   assign b_free    = !(b_we && b_blocked);
   assign wr_ok     = !mode_profibus && host_req && host_we;
   // trigger reply lands in the command's slot
   assign rx_base   = is_trig ? `FHB_MEM_AW'(trig_num_s * `FHB_CMD_SLOT) : `FHB_UNI_RX_DATA;

   always_comb begin
      next_state = state;          next_idx = idx;            next_len = len;
      next_rx_cnt = rx_cnt;        next_is_trig = is_trig;    next_tmr = tmr;
      next_idle_cnt = idle_cnt;    next_frame_open = frame_open;
      next_uni_rx_label = uni_rx_label;   next_uni_err = uni_err;
      next_trig_label = trig_label;       next_trig_num_s = trig_num_s;
      next_uni_tx_label = uni_tx_label;   next_uni_en = uni_en;
      next_trig_pend = trig_pend;  next_uni_pend = uni_pend;
      next_hart_tx_data = hart_tx_data;   next_hart_tx_valid = hart_tx_valid;
      next_ser_tx_data = ser_tx_data;     next_ser_tx_valid = ser_tx_valid;
      next_trig_num = trig_num;    next_hart_tx_end = 1'b0;   next_trig_req = 1'b0;
      next_b_we = b_we && b_blocked;
      next_b_waddr = b_waddr;      next_b_wdata = b_wdata;
      b_raddr = `FHB_UNI_TX_DATA;
      next_host_rvalid = a_en && !a_we;
      next_pb_refused = mode_profibus && pb_req && !pb_in_range;
      next_mod_bad = mod_bad || (mod_valid && !fhb_mod_ok(mod_kind, mod_words));
      next_cfg_err = next_mod_bad || (cfg_in_bytes > `FHB_PB_MAX_BYTES) ||
                     (cfg_out_bytes > `FHB_PB_MAX_BYTES) ||
                     (({1'b0, cfg_in_bytes} + {1'b0, cfg_out_bytes}) > `FHB_PB_MAX_TOTAL) ||
                     (cfg_mods > `FHB_PB_MAX_MODS);
      if (hart_tx_valid && hart_tx_ready) begin
         next_hart_tx_valid = 1'b0;
      end
      if (ser_tx_valid && ser_tx_ready) begin
         next_ser_tx_valid = 1'b0;
      end
      if (wr_ok && host_addr == `FHB_TRIG_NUM) begin
         next_trig_num_s = host_wdata;
      end
      if (wr_ok && host_addr == `FHB_UNI_EN) begin
         next_uni_en = host_wdata;
      end
      if (mode_common) begin
         // serial byte goes out unchanged; no buffer, busy drops it
         if (ser_rx_valid && !hart_tx_valid) begin
            next_hart_tx_data  = ser_rx_data;
            next_hart_tx_valid = 1'b1;
         end
         // HART byte back to serial unchanged
         if (hart_rx_valid && !ser_tx_valid) begin
            next_ser_tx_data  = hart_rx_data;
            next_ser_tx_valid = 1'b1;
         end
         if (ser_rx_valid) begin
            next_frame_open = 1'b1;
            next_idle_cnt   = 32'h0000_0000;
         end else if (frame_open) begin
            next_idle_cnt = idle_cnt + 32'h0000_0001;
            if (next_idle_cnt >= idle_lim) begin
               next_frame_open  = 1'b0;
               next_hart_tx_end = 1'b1;
            end
         end
      end else begin
         next_frame_open = 1'b0;
      end
      unique case (state)
         fhb_pkg::FHB_IDLE: begin
            // a new transaction starts only from idle
            if (!mode_common && uni_pend) begin
               next_uni_pend = 1'b0;
               if (uni_en == `FHB_UNI_EN_ON) begin
                  next_is_trig = 1'b0;
                  next_state   = fhb_pkg::FHB_LEN_H;
               end
            end else if (!mode_common && trig_pend) begin
               next_trig_pend = 1'b0;
               next_trig_req  = 1'b1;
               next_trig_num  = trig_num_s;
               next_is_trig   = 1'b1;
               next_rx_cnt    = 9'h000;
               next_tmr       = 32'h0000_0000;
               next_state     = fhb_pkg::FHB_WAIT;
            end
         end
         // read length then stream the send area
         fhb_pkg::FHB_LEN_H: begin
            b_raddr    = `FHB_UNI_TX_LEN_H;
            next_state = fhb_pkg::FHB_LEN_L;
         end
         fhb_pkg::FHB_LEN_L: begin
            b_raddr    = `FHB_UNI_TX_LEN_L;
            next_len   = {b_rdata[0], 8'h00};
            next_state = fhb_pkg::FHB_LEN_W;
         end
         fhb_pkg::FHB_LEN_W: begin
            // Lengths from 301 to 511 are clipped to the send area; bits 7:1 of the high byte are ignored
            next_len   = (len[8] && b_rdata > 8'h2c) ? `FHB_UNI_MAX_LEN : {len[8], b_rdata};
            next_idx   = 9'h000;
            next_state = fhb_pkg::FHB_FETCH;
         end
         fhb_pkg::FHB_FETCH: begin
            b_raddr = fhb_off(`FHB_UNI_TX_DATA, idx);
            if (idx == len) begin
               next_hart_tx_end = 1'b1;
               next_rx_cnt      = 9'h000;
               next_tmr         = 32'h0000_0000;
               next_state       = fhb_pkg::FHB_WAIT;
            end else begin
               next_state = fhb_pkg::FHB_LOAD;
            end
         end
         fhb_pkg::FHB_LOAD: begin
            next_hart_tx_data  = b_rdata;
            next_hart_tx_valid = 1'b1;
            next_state         = fhb_pkg::FHB_SEND;
         end
         fhb_pkg::FHB_SEND: begin
            if (hart_tx_ready) begin
               next_idx   = idx + 9'h001;
               next_state = fhb_pkg::FHB_FETCH;
            end
         end
         fhb_pkg::FHB_WAIT: begin
            next_tmr = tmr + 32'h0000_0001;
            // contiguous store; a byte meeting a held write is lost
            if (hart_rx_valid && b_free && rx_cnt < `FHB_UNI_MAX_LEN) begin
               next_b_we    = 1'b1;
               next_b_waddr = fhb_off(rx_base, rx_cnt);
               next_b_wdata = hart_rx_data;
               next_rx_cnt  = rx_cnt + 9'h001;
            end
            if (hart_rx_end && rx_cnt != 9'h000) begin
               next_state = is_trig ? fhb_pkg::FHB_IDLE : fhb_pkg::FHB_WR_LEN_H;
            end else if (rx_cnt == 9'h000 && tmr >= RESP_WAIT_CYC - 32'h0000_0001) begin
               next_state = is_trig ? fhb_pkg::FHB_IDLE : fhb_pkg::FHB_WR_ERR;
            end
         end
         fhb_pkg::FHB_WR_LEN_H: begin
            if (b_free) begin
               next_b_we    = 1'b1;
               next_b_waddr = `FHB_UNI_RX_LEN_H;
               next_b_wdata = {7'h00, rx_cnt[8]};
               next_state   = fhb_pkg::FHB_WR_LEN_L;
            end
         end
         fhb_pkg::FHB_WR_LEN_L: begin
            if (b_free) begin
               next_b_we    = 1'b1;
               next_b_waddr = `FHB_UNI_RX_LEN_L;
               next_b_wdata = rx_cnt[7:0];
               next_state   = fhb_pkg::FHB_WR_LABEL;
            end
         end
         fhb_pkg::FHB_WR_LABEL: begin
            // label moves only after data and length
            if (b_free) begin
               next_uni_rx_label = uni_rx_label + 8'h01;
               next_b_we         = 1'b1;
               next_b_waddr      = `FHB_UNI_RX_LABEL;
               next_b_wdata      = next_uni_rx_label;
               next_state        = fhb_pkg::FHB_IDLE;
            end
         end
         fhb_pkg::FHB_WR_ERR: begin
            if (b_free) begin
               next_uni_err = uni_err + 8'h01;
               next_b_we    = 1'b1;
               next_b_waddr = `FHB_UNI_RX_ERR;
               next_b_wdata = next_uni_err;
               next_state   = fhb_pkg::FHB_IDLE;
            end
         end
      endcase
      // Label changes set after the clear so a same-cycle change is kept
      if (wr_ok && host_addr == `FHB_TRIG_LABEL && host_wdata != trig_label) begin
         next_trig_label = host_wdata;
         next_trig_pend  = 1'b1;
      end
      if (wr_ok && host_addr == `FHB_UNI_TX_LABEL && host_wdata != uni_tx_label) begin
         next_uni_tx_label = host_wdata;
         next_uni_pend     = 1'b1;
      end
      unique case (next_state)
         fhb_pkg::FHB_IDLE:   next_gw_status = `FHB_ST_IDLE;
         fhb_pkg::FHB_WAIT:   next_gw_status = (next_rx_cnt != 9'h000) ? `FHB_ST_HANDLE
                                                                       : `FHB_ST_WAIT;
         fhb_pkg::FHB_WR_LEN_H, fhb_pkg::FHB_WR_LEN_L, fhb_pkg::FHB_WR_LABEL,
         fhb_pkg::FHB_WR_ERR: next_gw_status = `FHB_ST_HANDLE;
         default:             next_gw_status = `FHB_ST_SEND;
      endcase
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state <= fhb_pkg::FHB_IDLE;  idx <= 9'h000;  len <= 9'h000;  rx_cnt <= 9'h000;
         is_trig <= 1'b0;  tmr <= 32'h0000_0000;  idle_cnt <= 32'h0000_0000;
         frame_open <= 1'b0;  uni_rx_label <= 8'h00;  uni_err <= 8'h00;
         trig_label <= 8'h00;  trig_num_s <= 8'h00;  uni_tx_label <= 8'h00;
         uni_en <= 8'h00;  trig_pend <= 1'b0;  uni_pend <= 1'b0;
         hart_tx_data <= 8'h00;  hart_tx_valid <= 1'b0;  hart_tx_end <= 1'b0;
         ser_tx_data <= 8'h00;  ser_tx_valid <= 1'b0;  trig_req <= 1'b0;
         trig_num <= 8'h00;  host_rvalid <= 1'b0;  pb_refused <= 1'b0;
         cfg_err <= 1'b0;  mod_bad <= 1'b0;  gw_status <= `FHB_ST_IDLE;
         b_we <= 1'b0;  b_waddr <= `FHB_UNI_RX_DATA;  b_wdata <= 8'h00;
      end else begin
         state <= next_state;  idx <= next_idx;  len <= next_len;  rx_cnt <= next_rx_cnt;
         is_trig <= next_is_trig;  tmr <= next_tmr;  idle_cnt <= next_idle_cnt;
         frame_open <= next_frame_open;  uni_rx_label <= next_uni_rx_label;
         uni_err <= next_uni_err;  trig_label <= next_trig_label;
         trig_num_s <= next_trig_num_s;  uni_tx_label <= next_uni_tx_label;
         uni_en <= next_uni_en;  trig_pend <= next_trig_pend;  uni_pend <= next_uni_pend;
         hart_tx_data <= next_hart_tx_data;  hart_tx_valid <= next_hart_tx_valid;
         hart_tx_end <= next_hart_tx_end;  ser_tx_data <= next_ser_tx_data;
         ser_tx_valid <= next_ser_tx_valid;  trig_req <= next_trig_req;
         trig_num <= next_trig_num;  host_rvalid <= next_host_rvalid;
         pb_refused <= next_pb_refused;  cfg_err <= next_cfg_err;  mod_bad <= next_mod_bad;
         gw_status <= next_gw_status;  b_we <= next_b_we;
         b_waddr <= next_b_waddr;  b_wdata <= next_b_wdata;
      end
   end

   fhb_mem u_mem (
      .ref_clk (ref_clk),
      .a_en    (a_en),
      .a_we    (a_we),
      .a_addr  (a_addr),
      .a_wdata (a_wdata),
      .a_rdata (host_rdata),
      .b_raddr (b_raddr),
      .b_rdata (b_rdata),
      .b_we    (b_we && !b_blocked),
      .b_waddr (b_waddr),
      .b_wdata (b_wdata)
   );
endmodule
`default_nettype wire

/* File: include/fhb_defs.svh */
// Constants for the fieldbus to HART frame bridge
`ifndef FHB_DEFS_SVH
`define FHB_DEFS_SVH

`define FHB_MEM_AW          13
`define FHB_MEM_DEPTH       8192
`define FHB_CLK_HZ          200000000
`define FHB_RESP_WAIT_MS    500
`define FHB_BITS_PER_CHAR   10
`define FHB_IDLE_NUM        7
`define FHB_IDLE_DEN        2
`define FHB_PB_IN_BASE      13'h0000
`define FHB_PB_OUT_BASE     13'h0bb8
`define FHB_PB_MAX_BYTES    9'h0f4
`define FHB_PB_MAX_TOTAL    10'h1e8
`define FHB_PB_MAX_MODS     7'h40
`define FHB_UNI_RX_LABEL    13'h0958
`define FHB_UNI_RX_ERR      13'h0959
`define FHB_UNI_RX_LEN_H    13'h095a
`define FHB_UNI_RX_LEN_L    13'h095b
`define FHB_UNI_RX_DATA     13'h095c
`define FHB_UNI_MAX_LEN     9'h12c
`define FHB_TRIG_LABEL      13'h0fa2
`define FHB_TRIG_NUM        13'h0fa3
`define FHB_UNI_TX_LABEL    13'h10ae
`define FHB_UNI_EN          13'h10af
`define FHB_UNI_TX_LEN_H    13'h10b0
`define FHB_UNI_TX_LEN_L    13'h10b1
`define FHB_UNI_TX_DATA     13'h10b2
`define FHB_UNI_EN_ON       8'h01
`define FHB_CMD_SLOT        13'h0014
`define FHB_ST_IDLE         2'h0
`define FHB_ST_SEND         2'h1
`define FHB_ST_WAIT         2'h2
`define FHB_ST_HANDLE       2'h3
`define FHB_MOD_COMBO       2'h0
`define FHB_MOD_IN          2'h1
`define FHB_MOD_OUT         2'h2
`define FHB_MOD_CONS        2'h3

`endif

/* File: include/fhb_pkg.sv */
// Types for the fieldbus to HART frame bridge
package fhb_pkg;
   typedef enum logic [3:0] {
      FHB_IDLE, FHB_LEN_H, FHB_LEN_L, FHB_LEN_W, FHB_FETCH, FHB_LOAD, FHB_SEND,
      FHB_WAIT, FHB_WR_LEN_H, FHB_WR_LEN_L, FHB_WR_LABEL, FHB_WR_ERR
   } fhb_state_t;
endpackage

/* File: hw/fhb_mem.sv */
// Gateway byte memory: host port read/write, engine read port and write port
`timescale 1ns/1ps
`default_nettype none
`include "fhb_defs.svh"
module fhb_mem (
   input  wire logic                   ref_clk,
   input  wire logic                   a_en,
   input  wire logic                   a_we,
   input  wire logic [`FHB_MEM_AW-1:0] a_addr,
   input  wire logic [7:0]             a_wdata,
   output logic      [7:0]             a_rdata,
   input  wire logic [`FHB_MEM_AW-1:0] b_raddr,
   output logic      [7:0]             b_rdata,
   input  wire logic                   b_we,
   input  wire logic [`FHB_MEM_AW-1:0] b_waddr,
   input  wire logic [7:0]             b_wdata
);
   logic [7:0] mem [0:`FHB_MEM_DEPTH-1];

   // No reset: contents are undefined until written
   always_ff @(posedge ref_clk) begin
      if (a_en && a_we) begin
         mem[a_addr] <= a_wdata;
      end
      if (b_we) begin
         mem[b_waddr] <= b_wdata;
      end
      if (a_en && !a_we) begin
         a_rdata <= mem[a_addr];
      end
      b_rdata <= mem[b_raddr];
   end
endmodule
`default_nettype wire

/* File: tb/fhb_bridge_properties.sv */
// Port checks for the frame bridge
`timescale 1ns/1ps
`default_nettype none
module fhb_props (
   input wire logic       ref_clk,
   input wire logic       resetn,
   input wire logic       mode_common,
   input wire logic       mode_profibus,
   input wire logic [7:0] ser_rx_data,
   input wire logic       ser_rx_valid,
   input wire logic [7:0] ser_tx_data,
   input wire logic       ser_tx_valid,
   input wire logic [7:0] hart_tx_data,
   input wire logic       hart_tx_valid,
   input wire logic       hart_tx_ready,
   input wire logic [7:0] hart_rx_data,
   input wire logic       hart_rx_valid,
   input wire logic       trig_req,
   input wire logic       host_req,
   input wire logic       host_we,
   input wire logic       host_rvalid,
   input wire logic       pb_req,
   input wire logic       pb_we,
   input wire logic [7:0] pb_idx,
   input wire logic       pb_refused
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   sequence fwd_s;
      mode_common && ser_rx_valid && !hart_tx_valid;
   endsequence
   sequence pb_s;
      mode_profibus && pb_req;
   endsequence
   host_read_a: assert property (host_req && !host_we && !mode_profibus |=> host_rvalid)
      else $error("host read gave no answer");
   pb_refuse_a: assert property (pb_s ##0 pb_idx >= 8'hf4 |=> pb_refused)
      else $error("high index not refused");
   pb_accept_a: assert property (pb_s ##0 pb_idx < 8'hf4 |=> !pb_refused)
      else $error("legal index refused");
   pb_read_a: assert property (pb_s ##0 !pb_we && pb_idx < 8'hf4 |=> host_rvalid)
      else $error("buffer read gave no answer");
   ser_fwd_a: assert property (fwd_s |=> hart_tx_valid && hart_tx_data == $past(ser_rx_data))
      else $error("serial byte altered");
   hart_back_a: assert property (mode_common && hart_rx_valid && !ser_tx_valid
      |=> ser_tx_valid && ser_tx_data == $past(hart_rx_data))
      else $error("reply byte altered");
   trig_once_a: assert property (trig_req |=> !trig_req)
      else $error("trigger pulse too long");
   tx_hold_a: assert property (hart_tx_valid && !hart_tx_ready |=> hart_tx_valid && $stable(hart_tx_data))
      else $error("send byte dropped");
endmodule
bind fhb_bridge fhb_props u_fhb_props (.ref_clk, .resetn, .mode_common, .mode_profibus,
   .ser_rx_data, .ser_rx_valid, .ser_tx_data, .ser_tx_valid, .hart_tx_data, .hart_tx_valid,
   .hart_tx_ready, .hart_rx_data, .hart_rx_valid, .trig_req, .host_req, .host_we,
   .host_rvalid, .pb_req, .pb_we, .pb_idx, .pb_refused);
`default_nettype wire

/* File: tb/fhb_hart_dev.sv */
// Field device model: stalls every other cycle, answers with three bytes
`timescale 1ns/1ps
`default_nettype none
module fhb_hart_dev (
   input  wire logic       ref_clk,
   input  wire logic       silent,
   input  wire logic       hart_tx_end,
   input  wire logic       trig_req,
   output logic            hart_tx_ready,
   output logic [7:0]      hart_rx_data,
   output logic            hart_rx_valid,
   output logic            hart_rx_end
);
   initial hart_tx_ready = 1'b0;
   initial hart_rx_data = 8'h00;
   initial hart_rx_valid = 1'b0;
   initial hart_rx_end = 1'b0;
   // Half rate acceptance exercises the hold path
   always @(posedge ref_clk) hart_tx_ready <= ~hart_tx_ready;
   always @(posedge ref_clk) begin
      if ((hart_tx_end || trig_req) && !silent) begin
         for (int i = 0; i < 3; i++) begin
            repeat (2) @(posedge ref_clk);
            hart_rx_data <= 8'ha0 + 8'(i);
            hart_rx_valid <= 1'b1;
            @(posedge ref_clk);
            hart_rx_valid <= 1'b0;
            // Stale data is inverted so it cannot pass as fresh
            hart_rx_data <= ~hart_rx_data;
         end
         hart_rx_end <= 1'b1;
         @(posedge ref_clk);
         hart_rx_end <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the frame bridge
`timescale 1ns/1ps
`default_nettype none
`include "fhb_defs.svh"
module tb;
   logic        ref_clk = 0, resetn = 0, mode_common = 0, mode_profibus = 0, silent = 0;
   logic        ser_rx_valid = 0, ser_tx_valid, hart_tx_valid, hart_tx_ready, hart_tx_end;
   logic        hart_rx_valid, hart_rx_end, trig_req, host_req = 0, host_we = 0, host_rvalid;
   logic        pb_req = 0, pb_we = 0, pb_refused, mod_valid = 0, cfg_err, rf;
   logic [7:0]  ser_rx_data = 0, ser_tx_data, hart_tx_data, hart_rx_data, trig_num, rd, lab;
   logic [7:0]  host_wdata = 0, host_rdata, pb_idx = 0, pb_wdata = 0;
   logic [12:0] host_addr = 0;
   logic [1:0]  mod_kind = 0, gw_status;
   logic [6:0]  mod_words = 0, cfg_mods = 0;
   logic [8:0]  cfg_in_bytes = 0, cfg_out_bytes = 0;
   logic [7:0]  txq[$];
   int          err_total = 0, n_tests = 0, n;
   always #2.5 ref_clk = ~ref_clk;
   fhb_bridge #(.RESP_WAIT_CYC(32'd200)) u_fhb_bridge (.ref_clk, .resetn, .mode_common,
      .mode_profibus, .bit_cycles(16'h0004), .ser_rx_data, .ser_rx_valid, .ser_tx_data,
      .ser_tx_valid, .ser_tx_ready(1'b1), .hart_tx_data, .hart_tx_valid, .hart_tx_ready,
      .hart_tx_end, .hart_rx_data, .hart_rx_valid, .hart_rx_end, .trig_req, .trig_num,
      .host_req, .host_we, .host_addr, .host_wdata, .host_rdata, .host_rvalid, .pb_req,
      .pb_we, .pb_idx, .pb_wdata, .pb_lock(1'b0), .pb_refused, .mod_valid, .mod_kind,
      .mod_words, .cfg_in_bytes, .cfg_out_bytes, .cfg_mods, .cfg_err, .gw_status);
   fhb_hart_dev u_fhb_hart_dev (.ref_clk, .silent, .hart_tx_end, .trig_req, .hart_tx_ready,
      .hart_rx_data, .hart_rx_valid, .hart_rx_end);
   always @(posedge ref_clk) if (hart_tx_valid && hart_tx_ready) txq.push_back(hart_tx_data);
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic p, input logic w, input logic [12:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      pb_req <= p;
      host_req <= !p;
      host_we <= w;
      pb_we <= w;
      host_addr <= a;
      pb_idx <= a[7:0];
      host_wdata <= d;
      pb_wdata <= d;
      @(posedge ref_clk);
      pb_req <= 1'b0;
      host_req <= 1'b0;
      #1;
      rd = host_rdata;
      rf = pb_refused;
   endtask
   task automatic wait_idle;
      repeat (4) @(posedge ref_clk);
      for (n = 0; gw_status !== 2'h0 && n < 2000; n++) @(posedge ref_clk);
      chk(n < 2000, 1);
   endtask
   task automatic t_common;
      @(posedge ref_clk);
      mode_common <= 1'b1;
      ser_rx_data <= 8'h3c;
      ser_rx_valid <= 1'b1;
      @(posedge ref_clk);
      ser_rx_valid <= 1'b0;
      #1;
      chk(hart_tx_data, 8'h3c);
      for (n = 0; hart_tx_end !== 1'b1 && n < 200; n++) @(posedge ref_clk) #1;
      // Quiet gap is 4 cycles per bit times 10 times 3.5
      chk(n >= 138 && n <= 142, 1);
      for (n = 0; ser_tx_valid !== 1'b1 && n < 40; n++) @(posedge ref_clk) #1;
      chk(ser_tx_data, 8'ha0);
      repeat (20) @(posedge ref_clk);
      mode_common <= 1'b0;
   endtask
   task automatic t_uni;
      bus(0, 1, `FHB_UNI_RX_LABEL, 8'h00);
      bus(0, 1, `FHB_UNI_RX_ERR, 8'h00);
      bus(0, 1, `FHB_UNI_EN, 8'h01);
      bus(0, 1, `FHB_UNI_TX_LEN_H, 8'h00);
      bus(0, 1, `FHB_UNI_TX_LEN_L, 8'h02);
      bus(0, 1, `FHB_UNI_TX_DATA, 8'h11);
      bus(0, 1, `FHB_UNI_TX_DATA + 13'h0001, 8'h22);
      bus(0, 0, `FHB_UNI_RX_LABEL, 8'h00);
      lab = rd;
      bus(0, 1, `FHB_UNI_TX_LABEL, 8'h01);
      wait_idle;
      chk(9'(txq.size()), 9'd3);
      chk(txq[1], 8'h11);
      chk(txq[2], 8'h22);
      bus(0, 0, `FHB_UNI_RX_LABEL, 8'h00);
      chk(rd, lab + 8'h01);
      bus(0, 0, `FHB_UNI_RX_LEN_L, 8'h00);
      chk(rd, 8'h03);
      for (int i = 0; i < 3; i++) begin
         bus(0, 0, `FHB_UNI_RX_DATA + 13'(i), 8'h00);
         chk(rd, 8'ha0 + 8'(i));
      end
      silent <= 1'b1;
      bus(0, 1, `FHB_UNI_TX_LABEL, 8'h02);
      wait_idle;
      bus(0, 0, `FHB_UNI_RX_ERR, 8'h00);
      chk(rd, 8'h01);
      silent <= 1'b0;
      bus(0, 1, `FHB_UNI_EN, 8'h00);
      bus(0, 1, `FHB_UNI_TX_LABEL, 8'h03);
      repeat (30) @(posedge ref_clk);
      chk(9'(txq.size()), 9'd5);
   endtask
   task automatic t_trig;
      bus(0, 1, `FHB_TRIG_NUM, 8'h03);
      bus(0, 1, `FHB_TRIG_LABEL, 8'h01);
      for (n = 0; trig_req !== 1'b1 && n < 10; n++) @(posedge ref_clk) #1;
      chk(trig_num, 8'h03);
      wait_idle;
      bus(0, 0, 13'h003d, 8'h00);
      chk(rd, 8'ha1);
   endtask
   task automatic t_pb;
      bus(0, 1, 13'h0005, 8'h5a);
      mode_profibus <= 1'b1;
      bus(1, 0, 13'h0005, 8'h00);
      chk(rd, 8'h5a);
      bus(1, 1, 13'h0007, 8'h77);
      bus(1, 1, 13'h00f4, 8'hee);
      chk(rf, 1'b1);
      mode_profibus <= 1'b0;
      bus(0, 0, `FHB_PB_OUT_BASE + 13'h0007, 8'h00);
      chk(rd, 8'h77);
   endtask
   task automatic t_cfg;
      @(posedge ref_clk);
      cfg_in_bytes <= 9'h0f4;
      cfg_out_bytes <= 9'h0f4;
      cfg_mods <= 7'h40;
      repeat (2) @(posedge ref_clk);
      chk(cfg_err, 1'b0);
      cfg_mods <= 7'h41;
      repeat (2) @(posedge ref_clk);
      chk(cfg_err, 1'b1);
      cfg_mods <= 7'h40;
      cfg_out_bytes <= 9'h0f5;
      repeat (2) @(posedge ref_clk);
      chk(cfg_err, 1'b1);
      cfg_out_bytes <= 9'h000;
      cfg_in_bytes <= 9'h000;
      repeat (2) @(posedge ref_clk);
      chk(cfg_err, 1'b0);
   endtask
   task automatic t_mod(input logic [6:0] w, input logic e);
      @(posedge ref_clk);
      mod_valid <= 1'b1;
      mod_words <= w;
      @(posedge ref_clk);
      mod_valid <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk(cfg_err, e);
   endtask
   task automatic end_sim;
      if (err_total == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #100000;
      err_total++;
      end_sim;
   end
   initial begin
      repeat (4) @(posedge ref_clk);
      resetn <= 1'b1;
      t_common;
      t_uni;
      t_trig;
      t_pb;
      t_cfg;
      t_mod(7'h08, 1'b0);
      t_mod(7'h05, 1'b1);
      end_sim;
   end
endmodule
`default_nettype wire
